// ### design/acs_sequencer.sv
`timescale 1ns/10ps
// Operation
// RULE1 - calibration starts on low-then-high pulse of calPin or start_trim_bit write
// RULE2 - internal reset while calPin low; selected calibration starts after release
// RULE3 - busy rises at calPin rising edge or at end of control write
// RULE4 - busy stays high through every calibration type, drops when finished
// RULE5 - lengths 31.25 ms full, 6.94 ms gain+offset, 3.47 ms single at 4 MHz
// RULE6 - full calibration trims capacitor dac, then offset and gain; code trims dac, then gain, then offset
// RULE7 - gain plus offset corrects gain then offset, dac trim untouched
// RULE8 - offset-only trims offset, gain-only trims gain
// RULE9 - offset nulls midscale when bipolar, zero scale when unipolar; gain adjusts full scale
// RULE10 - power-on runs full self calibration once calPin rises
// RULE11 - host leaves converter alone until power-on calibration finishes
// RULE12 - host holds calPin low long enough to cover power-up time
// RULE13 - power-down-after-conversion mode powers up only for power-up plus conversion
// RULE14 - sleep pin ignored during power-on calibration
// RULE15 - calPin high at power-on skips automatic calibration
// RULE16 - lengths counted in master clock cycles so they scale with clock
// RULE17 - requests during busy are ignored
module acs_sequencer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // master clock enable, one pulse per converter clock
  input wire logic mclkTick,
  // host controls
  input wire logic calPin_n,
  input wire logic ctrlWrite,
  input wire logic start_trim_bit,
  input wire acs_pkg::acs_cal_type calType,
  input wire logic bipolar,
  input wire acs_pkg::acs_pm_type pmMode,
  input wire logic sleepPin_n,
  input wire logic convStart,
  input wire logic [acs_pkg::ACS_PUP_W-1:0] powerUpCycles,
  // status and trim strobes
  output logic busy,
  output logic internalReset,
  output logic powerUp,
  output logic trimDac,
  output logic trimGain,
  output logic trimOffset,
  output logic offsetAtMidscale,
  output logic gainAtFullScale,
  output logic converting
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic calPrev;
    logic firstCycle;
    logic powerOnCal;
    logic busy;
    logic internalReset;
    acs_phase_type phase;
    acs_cal_type active;
    logic powerUp;
    logic converting;
    logic [ACS_PUP_W-1:0] pupCount;
    logic waitConv;
    logic [ACS_CNT_W-1:0] convCount;
    logic bipolar;
    logic trimDac;
    logic trimGain;
    logic trimOffset;
    logic gainFullScale;
  } acs_seq_type;

  acs_seq_type st;
  acs_seq_type next_st;
  logic tmrLoad;
  logic [ACS_CNT_W-1:0] tmrValue;
  logic tmrExpired;

  function automatic logic [ACS_CNT_W-1:0] phaseLen(input acs_phase_type ph,
                                                    input acs_cal_type ty);
    logic [ACS_CNT_W-1:0] len;
    len = ACS_CNT_W'(ACS_CYC_SINGLE);
    if (ph == ACS_PH_DAC) begin
      len = ACS_CNT_W'(ACS_CYC_DAC);
    end else if (ty == ACS_CAL_FULL || ty == ACS_CAL_GAIN_OFS) begin
      // both halves of a dual trim share the gain+offset time
      len = ACS_CNT_W'(ACS_CYC_GO / 2);
      if (ph == ACS_PH_OFS) begin
        len = ACS_CNT_W'(ACS_CYC_GO - ACS_CYC_GO / 2);
      end
    end
    return len;
  endfunction : phaseLen

  function automatic acs_phase_type firstPhase(input acs_cal_type ty);
    acs_phase_type ph;
    ph = ACS_PH_GAIN;
    if (ty == ACS_CAL_FULL) begin
      ph = ACS_PH_DAC; // RULE6
    end else if (ty == ACS_CAL_OFS) begin
      ph = ACS_PH_OFS; // RULE8
    end
    return ph;
  endfunction : firstPhase

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    tmrLoad = 1'b0;
    tmrValue = '0;
    next_st.calPrev = calPin_n;
    next_st.firstCycle = 1'b0;
    // a high pin at the first sampled edge means no power-on calibration
    if (st.firstCycle && !calPin_n) begin
      next_st.powerOnCal = 1'b1; // RULE15
    end
    if (!calPin_n) begin
      // pin low holds the core in reset and aborts any run
      next_st.internalReset = 1'b1; // RULE2
      next_st.busy = 1'b0;
      next_st.phase = ACS_PH_IDLE;
    end else begin
      next_st.internalReset = 1'b0;
      if (!st.calPrev && !st.busy) begin
        next_st.busy = 1'b1; // RULE1 RULE3
        next_st.active = st.powerOnCal ? ACS_CAL_FULL : calType; // RULE10
        // forced full type is spent once; an aborted run must not force the next one
        next_st.powerOnCal = 1'b0;
        next_st.bipolar = bipolar;
        next_st.phase = firstPhase(next_st.active);
        tmrLoad = 1'b1;
        tmrValue = phaseLen(next_st.phase, next_st.active); // RULE5 RULE16
      end else if (ctrlWrite && start_trim_bit && !st.busy) begin
        next_st.busy = 1'b1; // RULE1 RULE3 RULE17
        next_st.active = calType;
        next_st.bipolar = bipolar;
        next_st.phase = firstPhase(calType);
        tmrLoad = 1'b1;
        tmrValue = phaseLen(next_st.phase, calType);
      end else if (st.busy && tmrExpired) begin
        case (st.phase)
          ACS_PH_DAC: begin
            next_st.phase = ACS_PH_GAIN; // RULE6
          end
          ACS_PH_GAIN: begin
            next_st.phase = (st.active == ACS_CAL_GAIN) ? ACS_PH_DONE : ACS_PH_OFS; // RULE7
          end
          default: begin
            next_st.phase = ACS_PH_DONE;
          end
        endcase
        if (next_st.phase == ACS_PH_DONE) begin
          next_st.busy = 1'b0; // RULE4
          next_st.phase = ACS_PH_IDLE;
          next_st.powerOnCal = 1'b0;
        end else begin
          tmrLoad = 1'b1;
          tmrValue = phaseLen(next_st.phase, st.active);
        end
      end
    end
    // power management; calibration always keeps the core powered
    if (st.busy || st.powerOnCal) begin
      next_st.powerUp = 1'b1; // RULE14
    end else begin
      case (pmMode)
        ACS_PM_NORMAL: begin
          next_st.powerUp = 1'b1;
        end
        ACS_PM_SLEEP_PIN: begin
          next_st.powerUp = sleepPin_n || st.waitConv || st.converting; // RULE13
        end
        ACS_PM_PARTIAL: begin
          next_st.powerUp = st.waitConv || st.converting;
        end
        default: begin
          next_st.powerUp = 1'b0;
        end
      endcase
    end
    // conversion: power-up interval, then fixed conversion length
    if (convStart && !st.waitConv && !st.converting && !st.busy) begin
      next_st.waitConv = 1'b1;
      next_st.pupCount = powerUpCycles;
    end else if (st.waitConv && mclkTick) begin
      if (st.pupCount == '0) begin
        next_st.waitConv = 1'b0;
        next_st.converting = 1'b1;
        next_st.convCount = ACS_CNT_W'(ACS_CYC_CONV); // RULE13
      end else begin
        next_st.pupCount = st.pupCount - 1'b1;
      end
    end else if (st.converting && mclkTick) begin
      if (st.convCount <= {{(ACS_CNT_W-1){1'b0}}, 1'b1}) begin
        next_st.converting = 1'b0;
      end else begin
        next_st.convCount = st.convCount - 1'b1;
      end
    end
    if (!calPin_n) begin
      next_st.waitConv = 1'b0;
      next_st.converting = 1'b0;
    end
    // strobes decoded from the next state so each output leaves a flip-flop
    next_st.trimDac = next_st.busy && next_st.phase == ACS_PH_DAC; // RULE6
    next_st.trimGain = next_st.busy && next_st.phase == ACS_PH_GAIN; // RULE8
    next_st.trimOffset = next_st.busy && next_st.phase == ACS_PH_OFS; // RULE8
    next_st.gainFullScale = 1'b1; // RULE9
  end

  // ----------------------------------------------------------------
  // registers and timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.calPrev <= 1'b1;
      st.firstCycle <= 1'b1;
      st.active <= acs_cal_type'(ACS_RST_TYPE);
      st.gainFullScale <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  acs_phase_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tmrLoad),
    .loadValue(tmrValue),
    .tick(mclkTick),
    .expired(tmrExpired)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy = st.busy;
  assign internalReset = st.internalReset;
  assign powerUp = st.powerUp;
  assign converting = st.converting;
  assign trimDac = st.trimDac; // RULE6
  assign trimGain = st.trimGain; // RULE8
  assign trimOffset = st.trimOffset; // RULE8
  assign offsetAtMidscale = st.bipolar; // RULE9
  assign gainAtFullScale = st.gainFullScale; // RULE9

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pin_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (!st.calPrev && calPin_n && !st.busy) |=> busy;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("busy missed pin release"); // RULE3

  property p_sw_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (calPin_n && st.calPrev && ctrlWrite && start_trim_bit && !busy) |=> busy;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("busy missed write"); // RULE1

  property p_reset_low;
    @(posedge ref_clk) disable iff (!rst_n)
    !calPin_n |=> internalReset && !busy;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("no reset while pin low"); // RULE2

  property p_dac_then_gain;
    @(posedge ref_clk) disable iff (!rst_n)
    (trimDac && tmrExpired && calPin_n) |=> trimGain;
  endproperty
  a_dac_then_gain: assert property (p_dac_then_gain) else $error("dac not followed by gain"); // RULE6

  property p_go_no_dac;
    @(posedge ref_clk) disable iff (!rst_n)
    (busy && st.active != ACS_CAL_FULL) |-> !trimDac;
  endproperty
  a_go_no_dac: assert property (p_go_no_dac) else $error("dac trimmed in partial cal"); // RULE7

  property p_single;
    @(posedge ref_clk) disable iff (!rst_n)
    (busy && st.active == ACS_CAL_OFS) |-> !trimGain;
  endproperty
  a_single: assert property (p_single) else $error("gain trimmed in offset cal"); // RULE8

  property p_busy_ignore;
    @(posedge ref_clk) disable iff (!rst_n)
    (busy && calPin_n && !tmrExpired) |=> busy && $stable(st.active);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("request taken while busy"); // RULE17

  property p_powered;
    @(posedge ref_clk) disable iff (!rst_n)
    busy |=> powerUp;
  endproperty
  a_powered: assert property (p_powered) else $error("powered down during cal"); // RULE14

  property p_poweron_full;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.powerOnCal && !st.calPrev && calPin_n && !busy) |=> trimDac;
  endproperty
  a_poweron_full: assert property (p_poweron_full) else $error("power-on run not full"); // RULE10

  property p_no_auto;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.firstCycle && calPin_n) |=> !st.powerOnCal;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("auto cal armed with pin high"); // RULE15
endmodule : acs_sequencer

// ### design/acs_pkg.sv
package acs_pkg;
  // ----------------------------------------------------------------
  // calibration types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACS_CAL_FULL = 2'b00,
    ACS_CAL_GAIN_OFS = 2'b01,
    ACS_CAL_OFS = 2'b10,
    ACS_CAL_GAIN = 2'b11
  } acs_cal_type;

  // phases of a calibration; the dac, gain and offset phases each drive one trim strobe
  typedef enum logic [2:0] {
    ACS_PH_IDLE = 3'b000,
    ACS_PH_DAC = 3'b001,
    ACS_PH_GAIN = 3'b010,
    ACS_PH_OFS = 3'b011,
    ACS_PH_DONE = 3'b100
  } acs_phase_type;

  // power management modes seen by the sequencer
  typedef enum logic [1:0] {
    ACS_PM_SLEEP_PIN = 2'b00,
    ACS_PM_NORMAL = 2'b01,
    ACS_PM_FULL_DOWN = 2'b10,
    ACS_PM_PARTIAL = 2'b11
  } acs_pm_type;

  // ----------------------------------------------------------------
  // timing, counted in master clock cycles
  // ----------------------------------------------------------------
  localparam int ACS_MCLK_KHZ = 4000;
  localparam real ACS_T_FULL_MS = 31.25;
  localparam real ACS_T_GO_MS = 6.94;
  localparam real ACS_T_SINGLE_MS = 3.47;
  localparam real ACS_T_CONV_US = 4.6;
  localparam int ACS_CYC_FULL = int'(ACS_T_FULL_MS * ACS_MCLK_KHZ);
  localparam int ACS_CYC_GO = int'(ACS_T_GO_MS * ACS_MCLK_KHZ);
  localparam int ACS_CYC_SINGLE = int'(ACS_T_SINGLE_MS * ACS_MCLK_KHZ);
  localparam int ACS_CYC_CONV = int'(ACS_T_CONV_US * ACS_MCLK_KHZ / 1000.0);
  // share of a full run spent trimming the capacitor dac
  localparam int ACS_CYC_DAC = ACS_CYC_FULL - ACS_CYC_GO;
  localparam int ACS_CNT_W = 20;
  localparam int ACS_PUP_W = 16;
  localparam logic [ACS_PUP_W-1:0] ACS_PUP_DEF = 16'h0014;
  localparam logic [1:0] ACS_RST_TYPE = 2'h0;
endpackage : acs_pkg

// ### design/acs_phase_timer.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// down counter paced by the master clock enable
// ------------------------------------------------------------------
module acs_phase_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [acs_pkg::ACS_CNT_W-1:0] loadValue,
  input wire logic tick,
  // status
  output logic expired
);
  import acs_pkg::*;

  typedef struct packed {
    logic [ACS_CNT_W-1:0] count;
    logic expired;
  } acs_tmr_type;

  acs_tmr_type st;
  acs_tmr_type next_st;

  always_comb begin
    next_st = st;
    next_st.expired = 1'b0;
    if (load) begin
      next_st.count = loadValue;
    end else if (tick && st.count != '0) begin
      next_st.count = st.count - 1'b1;
      next_st.expired = (st.count == {{(ACS_CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;
endmodule : acs_phase_timer

// ### bench/acs_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// host side: calibration pin and control writes
// ------------------------------------------------------------------
module acs_host_model (
  // clock
  input wire logic ref_clk,
  // calibration controls
  output logic calPin_n,
  output logic ctrlWrite,
  output logic start_trim_bit,
  output acs_pkg::acs_cal_type calType,
  output logic bipolar
);
  import acs_pkg::*;
  // long enough to cover power-up from full power-down
  localparam int HOLD = 24;
  // external capacitor keeps the pin low at power-on
  initial begin
    calPin_n = 1'b0;
    ctrlWrite = 1'b0;
    start_trim_bit = 1'b0;
    calType = ACS_CAL_FULL;
    bipolar = 1'b0;
  end
  task pin_low(input acs_cal_type ty, input logic bi);
    @(posedge ref_clk);
    calPin_n <= 1'b0;
    calType <= ty;
    bipolar <= bi;
    repeat (HOLD) @(posedge ref_clk);
  endtask : pin_low
  task pin_high();
    @(posedge ref_clk);
    calPin_n <= 1'b1;
  endtask : pin_high
  task sw_cal(input acs_cal_type ty, input logic bi);
    @(posedge ref_clk);
    ctrlWrite <= 1'b1;
    start_trim_bit <= 1'b1;
    calType <= ty;
    bipolar <= bi;
    @(posedge ref_clk);
    ctrlWrite <= 1'b0;
    start_trim_bit <= 1'b0;
  endtask : sw_cal
endmodule : acs_host_model

// ### bench/test_adc_calibration_sequencer.sv
`timescale 1ns/10ps
module test_adc_calibration_sequencer;
  import acs_pkg::*;
  // ------------------------------------------------------------------
  // design pins
  // ------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mclkTick = 1'b1;
  logic halfRate = 1'b0;
  logic sleepPin_n = 1'b0;
  logic convStart = 1'b0;
  acs_pm_type pmMode = ACS_PM_SLEEP_PIN;
  logic [ACS_PUP_W-1:0] powerUpCycles = ACS_PUP_DEF;
  logic calPin_n, ctrlWrite, start_trim_bit, bipolar;
  acs_cal_type calType;
  logic busy, internalReset, powerUp, trimDac, trimGain, trimOffset;
  logic offsetAtMidscale, gainAtFullScale, converting;
  int failCount = 0;
  int numChecks = 0;
  int nB, nD, nG, nO, first;
  always #2 ref_clk = ~ref_clk;
  // half rate shows that run lengths follow the converter clock
  always @(posedge ref_clk) begin
    mclkTick <= halfRate ? !mclkTick : 1'b1;
  end
  acs_host_model host (.ref_clk(ref_clk), .calPin_n(calPin_n), .ctrlWrite(ctrlWrite),
    .start_trim_bit(start_trim_bit), .calType(calType), .bipolar(bipolar));
  acs_sequencer uut (.ref_clk(ref_clk), .rst_n(rst_n), .mclkTick(mclkTick),
    .calPin_n(calPin_n), .ctrlWrite(ctrlWrite), .start_trim_bit(start_trim_bit),
    .calType(calType), .bipolar(bipolar), .pmMode(pmMode), .sleepPin_n(sleepPin_n),
    .convStart(convStart), .powerUpCycles(powerUpCycles), .busy(busy),
    .internalReset(internalReset), .powerUp(powerUp), .trimDac(trimDac),
    .trimGain(trimGain), .trimOffset(trimOffset), .offsetAtMidscale(offsetAtMidscale),
    .gainAtFullScale(gainAtFullScale), .converting(converting));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check
  // timer load latency makes the last few cycles uncertain
  function automatic int near(input int v, input int e);
    return (v >= e - 3 && v <= e + 3) ? e : v;
  endfunction : near
  task finishTest();
    $display("checks %0d, mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finishTest
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task pin_start(input acs_cal_type ty, input logic bi);
    host.pin_low(ty, bi);
    #1;
    check(32'(internalReset), 1);
    check(32'(busy), 0);
    host.pin_high();
    settle(1);
    check(32'(busy), 1);
  endtask : pin_start
  task sw_start(input acs_cal_type ty, input logic bi);
    host.sw_cal(ty, bi);
    #1;
    check(32'(busy), 1);
  endtask : sw_start
  // follows a run to its end, counting busy cycles and trim strobes
  task measure();
    nB = 0;
    nD = 0;
    nG = 0;
    nO = 0;
    first = 0;
    // never sample in the time step of the launching edge
    #1;
    while (busy === 1'b1 && nB < 200000) begin
      if (first == 0) first = trimDac ? 1 : trimGain ? 2 : trimOffset ? 3 : 0;
      nD += int'(trimDac);
      nG += int'(trimGain);
      nO += int'(trimOffset);
      settle(1);
      nB++;
    end
  endtask : measure
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // power-on run is full whatever type is selected
    pin_start(ACS_CAL_GAIN, 1'b0);
    settle(2);
    check(32'(trimDac), 1);
    check(32'(trimGain), 0);
    check(32'(powerUp), 1);
    // pin low aborts it, then an offset-only run
    pin_start(ACS_CAL_OFS, 1'b1);
    check(32'(offsetAtMidscale), 1);
    check(32'(gainAtFullScale), 1);
    measure();
    check(near(nB, ACS_CYC_SINGLE), ACS_CYC_SINGLE);
    check(near(nO, ACS_CYC_SINGLE), ACS_CYC_SINGLE);
    check(nG + nD, 0);
    sw_start(ACS_CAL_GAIN_OFS, 1'b0);
    check(32'(offsetAtMidscale), 0);
    // request inside the run must be ignored
    host.sw_cal(ACS_CAL_FULL, 1'b1);
    measure();
    check(near(nB, ACS_CYC_GO), ACS_CYC_GO);
    check(first, 2);
    check(near(nG, ACS_CYC_GO / 2), ACS_CYC_GO / 2);
    check(near(nO, ACS_CYC_GO / 2), ACS_CYC_GO / 2);
    check(nD, 0);
    @(posedge ref_clk);
    halfRate <= 1'b1;
    sw_start(ACS_CAL_GAIN, 1'b0);
    measure();
    check(near(nB, 2 * ACS_CYC_SINGLE), 2 * ACS_CYC_SINGLE);
    check(near(nG, 2 * ACS_CYC_SINGLE), 2 * ACS_CYC_SINGLE);
    check(nO + nD, 0);
    @(posedge ref_clk);
    halfRate <= 1'b0;
    pin_start(ACS_CAL_FULL, 1'b0);
    settle(2);
    check(32'(trimDac), 1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    settle(2);
    check(32'(busy), 0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(10);
    check(32'(busy), 0);
    check(32'(powerUp), 0);
    @(posedge ref_clk);
    pmMode <= ACS_PM_SLEEP_PIN;
    convStart <= 1'b1;
    @(posedge ref_clk);
    convStart <= 1'b0;
    nD = 0;
    nO = 0;
    for (int i = 0; i < 200; i++) begin
      nD += int'(powerUp);
      nO += int'(converting);
      settle(1);
    end
    check(near(nD, ACS_PUP_DEF + ACS_CYC_CONV), ACS_PUP_DEF + ACS_CYC_CONV);
    check(near(nO, ACS_CYC_CONV), ACS_CYC_CONV);
    finishTest();
  end
  // well above the expected run length, under the cycle budget
  initial begin
    #400000;
    failCount++;
    finishTest();
  end
endmodule : test_adc_calibration_sequencer
